/* common/adcsc_map.vh */
// register map, field positions and timing constants of the converter setup block
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

// register select codes
`define ADCSC_RS_COMM      2'h0
`define ADCSC_RS_SETUP     2'h1
`define ADCSC_RS_TEST      2'h2
`define ADCSC_RS_DATA      2'h3

// converter_setup reset value and field positions
`define ADCSC_SETUP_RST    8'h28
`define ADCSC_MODE_HI      7
`define ADCSC_MODE_LO      6
`define ADCSC_MCLK_SEL     5
`define ADCSC_RATE_HI      4
`define ADCSC_RATE_LO      3
`define ADCSC_UNIPOLAR     2
`define ADCSC_BUF_EN       1
`define ADCSC_FILTER_HOLD  0
`define ADCSC_MODE_NORMAL  2'h0

// communications word field positions
`define ADCSC_CW_RS_HI     5
`define ADCSC_CW_RS_LO     4
`define ADCSC_CW_RW        3
`define ADCSC_CW_STBY      2
`define ADCSC_CW_GAIN_HI   1

// output update rates in hz, indexed by {mclk_sel, rate_sel}
`define ADCSC_RATE_0       20
`define ADCSC_RATE_1       25
`define ADCSC_RATE_2       100
`define ADCSC_RATE_3       200
`define ADCSC_RATE_4       50
`define ADCSC_RATE_5       60
`define ADCSC_RATE_6       250
`define ADCSC_RATE_7       500

// word periods until the first word after a filter restart, and calibration length less one word period
`define ADCSC_SETTLE_WORDS 2'h3
`define ADCSC_CAL_WORDS    2'h3

// serial framing
`define ADCSC_BYTE_LAST    5'h07
`define ADCSC_WORD_LAST    5'h0f
`define ADCSC_ONES_LAST    6'h1f
`define ADCSC_CLK_HZ       125000000

`endif

/* src/adcsc_setup_ctrl.v */
// setup register, serial register port and word timing of the converter
//
// Behaviour
// - reset loads setup register with 28 hex
// - setup register is eight bits, read and write
// - register select 01 addresses setup register
// - clock bit reads one after reset
// - clock bit and rate bits pick rate
// - one new word per notch period
// - unsynchronised step settles within four periods
// - polarity bit zero bipolar, one unipolar
// - buffer bit low bypasses, high inserts buffer
// - filter hold resets filter, calibration, modulator
// - first valid word three periods after release
// - hold leaves interface and low ready alone
// - status bit read equals ready pin level
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_map.vh"

module adcsc_setup_ctrl #(
  parameter CLK_FREQ_HZ = `ADCSC_CLK_HZ
) (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // serial port pins
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        din,
  output wire        dout,
  output wire        dout_oe,
  output wire        result_ready_n,
  // modulator result and analog controls
  input  wire [15:0] sample_word,
  output wire [1:0]  op_mode,
  output wire        mclk_sel,
  output wire [1:0]  update_rate_sel,
  output wire        unipolar,
  output wire        buffer_en,
  output wire        filter_hold,
  output wire        modulator_rst,
  output wire        cal_active,
  output wire        standby,
  output wire [1:0]  gain_sel
);

  // ****************************************************************
  // constants and functions
  // ****************************************************************
  localparam [2:0] ST_COMM = 3'b001;
  localparam [2:0] ST_WR   = 3'b010;
  localparam [2:0] ST_RD   = 3'b100;

  localparam [31:0] PER_0 = CLK_FREQ_HZ / `ADCSC_RATE_0;
  localparam [31:0] PER_1 = CLK_FREQ_HZ / `ADCSC_RATE_1;
  localparam [31:0] PER_2 = CLK_FREQ_HZ / `ADCSC_RATE_2;
  localparam [31:0] PER_3 = CLK_FREQ_HZ / `ADCSC_RATE_3;
  localparam [31:0] PER_4 = CLK_FREQ_HZ / `ADCSC_RATE_4;
  localparam [31:0] PER_5 = CLK_FREQ_HZ / `ADCSC_RATE_5;
  localparam [31:0] PER_6 = CLK_FREQ_HZ / `ADCSC_RATE_6;
  localparam [31:0] PER_7 = CLK_FREQ_HZ / `ADCSC_RATE_7;

  // word period in clock cycles for {mclk_sel, rate_sel}
  function [31:0] word_period;
    input [2:0] code;
    begin
      case (code)
        3'h0:    word_period = PER_0;
        3'h1:    word_period = PER_1;
        3'h2:    word_period = PER_2;
        3'h3:    word_period = PER_3;
        3'h4:    word_period = PER_4;
        3'h5:    word_period = PER_5;
        3'h6:    word_period = PER_6;
        default: word_period = PER_7;
      endcase
    end
  endfunction

  // ****************************************************************
  // pin synchronisers and sclk edges
  // ****************************************************************
  reg [2:0] sclk_q;
  reg [1:0] cs_n_q;
  reg [1:0] din_q;

  always @(posedge mclk) begin
    if (sys_rst) begin
      sclk_q <= 3'h0;
      cs_n_q <= 2'h3;
      din_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_n_q <= {cs_n_q[0], cs_n};
      din_q  <= {din_q[0], din};
    end
  end

  wire sel    = ~cs_n_q[1];
  wire bit_in = din_q[1];
  wire s_rise = sel & sclk_q[1] & ~sclk_q[2];
  wire s_fall = sel & ~sclk_q[1] & sclk_q[2];

  // ****************************************************************
  // serial register port
  // ****************************************************************
  reg  [2:0]  st_q;
  reg  [4:0]  bit_q;
  reg  [4:0]  last_q;
  reg  [15:0] sh_q;
  reg  [5:0]  ones_q;
  reg  [1:0]  rs_q;
  reg         stby_q;
  reg  [1:0]  gain_q;
  reg         dout_q;
  reg         setup_wr_q;
  reg  [7:0]  setup_wdata_q;
  reg         data_rd_q;
  reg  [7:0]  setup_q;
  reg  [15:0] data_q;
  reg         rdy_n_q;

  wire [7:0] cw_new = {sh_q[6:0], bit_in};
  wire [1:0] rs_new = cw_new[`ADCSC_CW_RS_HI:`ADCSC_CW_RS_LO];

  // value presented for a read of the newly selected register
  reg [15:0] rd_val;
  always @* begin
    case (rs_new)
      `ADCSC_RS_COMM:  rd_val = {rdy_n_q, 1'b0, rs_new, 1'b1,
                                 cw_new[`ADCSC_CW_STBY], cw_new[`ADCSC_CW_GAIN_HI:0],
                                 8'h00};
      `ADCSC_RS_SETUP: rd_val = {setup_q, 8'h00};
      `ADCSC_RS_DATA:  rd_val = data_q;
      default:         rd_val = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q          <= ST_COMM;
      bit_q         <= 5'h00;
      last_q        <= `ADCSC_BYTE_LAST;
      sh_q          <= 16'h0000;
      ones_q        <= 6'h00;
      rs_q          <= `ADCSC_RS_COMM;
      stby_q        <= 1'b0;
      gain_q        <= 2'h0;
      dout_q        <= 1'b0;
      setup_wr_q    <= 1'b0;
      setup_wdata_q <= 8'h00;
      data_rd_q     <= 1'b0;
    end else begin
      setup_wr_q <= 1'b0;
      data_rd_q  <= 1'b0;
      if (!sel) begin
        bit_q <= 5'h00;
      end else if (s_fall && st_q == ST_RD) begin
        dout_q <= sh_q[15];
      end else if (s_rise) begin
        ones_q <= bit_in ? ones_q + 6'h01 : 6'h00;
        if (bit_in && ones_q == `ADCSC_ONES_LAST) begin
          // 32 ones in a row put the port back to the communications write
          st_q   <= ST_COMM;
          bit_q  <= 5'h00;
          ones_q <= 6'h00;
        end else begin
          case (st_q)
            ST_COMM: begin
              if (bit_q != 5'h00 || !bit_in) begin
                sh_q  <= {sh_q[14:0], bit_in};
                bit_q <= bit_q + 5'h01;
                if (bit_q == `ADCSC_BYTE_LAST) begin
                  bit_q  <= 5'h00;
                  rs_q   <= rs_new;
                  stby_q <= cw_new[`ADCSC_CW_STBY];
                  gain_q <= cw_new[`ADCSC_CW_GAIN_HI:0];
                  last_q <= (rs_new == `ADCSC_RS_DATA) ? `ADCSC_WORD_LAST
                                                       : `ADCSC_BYTE_LAST;
                  if (cw_new[`ADCSC_CW_RW]) begin
                    st_q   <= ST_RD;
                    sh_q   <= rd_val;
                    dout_q <= rd_val[15];
                  end else begin
                    st_q <= ST_WR;
                  end
                end
              end
            end
            ST_WR: begin
              sh_q  <= {sh_q[14:0], bit_in};
              bit_q <= bit_q + 5'h01;
              if (bit_q == last_q) begin
                st_q  <= ST_COMM;
                bit_q <= 5'h00;
                if (rs_q == `ADCSC_RS_SETUP) begin
                  setup_wr_q    <= 1'b1;
                  setup_wdata_q <= cw_new;
                end
              end
            end
            ST_RD: begin
              sh_q  <= {sh_q[14:0], 1'b0};
              bit_q <= bit_q + 5'h01;
              if (bit_q == last_q) begin
                st_q      <= ST_COMM;
                bit_q     <= 5'h00;
                data_rd_q <= (rs_q == `ADCSC_RS_DATA);
              end
            end
            default: st_q <= ST_COMM;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // setup register, word timer, settling and calibration
  // ****************************************************************
  reg  [31:0] tmr_q;
  reg  [1:0]  settle_q;
  reg         cal_q;

  wire        hold_w = setup_q[`ADCSC_FILTER_HOLD];
  wire [31:0] period = word_period(setup_q[`ADCSC_MCLK_SEL:`ADCSC_RATE_LO]);
  wire        tick   = (tmr_q == period - 32'h1);

  always @(posedge mclk) begin
    if (sys_rst) begin
      setup_q  <= `ADCSC_SETUP_RST;
      tmr_q    <= 32'h0;
      settle_q <= `ADCSC_SETTLE_WORDS;
      cal_q    <= 1'b0;
      data_q   <= 16'h0000;
      rdy_n_q  <= 1'b1;
    end else begin
      if (data_rd_q)
        rdy_n_q <= 1'b1;
      if (setup_wr_q) begin
        setup_q <= setup_wdata_q;
        tmr_q   <= 32'h0;
        if (setup_wdata_q[`ADCSC_MODE_HI:`ADCSC_MODE_LO] != `ADCSC_MODE_NORMAL) begin
          cal_q    <= 1'b1;
          settle_q <= `ADCSC_CAL_WORDS;
          rdy_n_q  <= 1'b1;
        end else begin
          cal_q    <= 1'b0;
          settle_q <= `ADCSC_SETTLE_WORDS;
        end
      end else if (hold_w) begin
        // a running calibration keeps its flag and starts over on release
        tmr_q    <= 32'h0;
        settle_q <= `ADCSC_SETTLE_WORDS;
      end else if (tick) begin
        tmr_q <= 32'h0;
        // the last settling period already yields a word, except during calibration
        if (settle_q > 2'h1 || (cal_q && settle_q == 2'h1)) begin
          settle_q <= settle_q - 2'h1;
        end else begin
          settle_q <= 2'h0;
          data_q  <= sample_word;
          rdy_n_q <= 1'b0;
          if (cal_q) begin
            cal_q <= 1'b0;
            setup_q[`ADCSC_MODE_HI:`ADCSC_MODE_LO] <= `ADCSC_MODE_NORMAL;
          end
        end
      end else begin
        tmr_q <= tmr_q + 32'h1;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dout            = dout_q;
  assign dout_oe         = sel & (st_q == ST_RD);
  assign result_ready_n  = rdy_n_q;
  assign op_mode         = setup_q[`ADCSC_MODE_HI:`ADCSC_MODE_LO];
  assign mclk_sel        = setup_q[`ADCSC_MCLK_SEL];
  assign update_rate_sel = setup_q[`ADCSC_RATE_HI:`ADCSC_RATE_LO];
  assign unipolar        = setup_q[`ADCSC_UNIPOLAR];
  assign buffer_en       = setup_q[`ADCSC_BUF_EN];
  assign filter_hold     = hold_w;
  assign modulator_rst   = hold_w;
  assign cal_active      = cal_q;
  assign standby         = stby_q;
  assign gain_sel        = gain_q;

endmodule

`default_nettype wire

/* bench/adcsc_setup_ctrl_chk.sv */
// port assertions of the converter setup block
`timescale 1ns/10ps
`default_nettype none
module adcsc_setup_ctrl_chk #(
  parameter CLK_FREQ_HZ = 125000000
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // watched ports
  input wire logic       cs_n,
  input wire logic       dout_oe,
  input wire logic       result_ready_n,
  input wire logic [1:0] op_mode,
  input wire logic       mclk_sel,
  input wire logic [1:0] update_rate_sel,
  input wire logic       unipolar,
  input wire logic       buffer_en,
  input wire logic       filter_hold,
  input wire logic       modulator_rst,
  input wire logic       cal_active
);
  // ****
  // word spacing helper
  // ****
  localparam int MIN_GAP = CLK_FREQ_HZ / 500;
  logic        rdy_q;
  logic [31:0] gap_q;
  wire         fall = rdy_q & ~result_ready_n;
  always @(posedge mclk) begin
    rdy_q <= result_ready_n;
    if (sys_rst || fall)
      gap_q <= 32'h0;
    else if (gap_q != 32'hffffffff)
      gap_q <= gap_q + 32'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_RST_VALUE: assert property ($fell(sys_rst) |-> op_mode == 2'h0 && update_rate_sel == 2'h1
    && !unipolar && !buffer_en && !filter_hold) else $error("setup fields wrong after reset");
  AST_CLK_BIT: assert property ($fell(sys_rst) |-> mclk_sel) else $error("clock bit low");
  AST_HOLD_MOD: assert property (modulator_rst == filter_hold) else $error("modulator reset");
  AST_HOLD_NO_WORD: assert property (filter_hold && result_ready_n |=> result_ready_n)
    else $error("word while held");
  AST_HOLD_KEEP_LOW: assert property ($rose(filter_hold) && !$past(result_ready_n)
    |-> !result_ready_n) else $error("hold raised ready");
  AST_CAL_NOT_READY: assert property (cal_active |-> result_ready_n) else $error("cal ready");
  AST_CAL_MODE_CLEAR: assert property ($fell(cal_active) |-> ##[0:2] op_mode == 2'h0)
    else $error("mode not cleared");
  AST_CAL_LENGTH: assert property ($rose(cal_active) |=> cal_active[*8])
    else $error("calibration too short");
  AST_WORD_GAP: assert property (fall |-> gap_q >= MIN_GAP - 1) else $error("words too close");
  AST_OE_SELECT: assert property (dout_oe |-> !cs_n) else $error("driving unselected");
endmodule
bind adcsc_setup_ctrl adcsc_setup_ctrl_chk #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .cs_n(cs_n), .dout_oe(dout_oe), .result_ready_n(result_ready_n),
  .op_mode(op_mode), .mclk_sel(mclk_sel), .update_rate_sel(update_rate_sel),
  .unipolar(unipolar), .buffer_en(buffer_en), .filter_hold(filter_hold),
  .modulator_rst(modulator_rst), .cal_active(cal_active));
`default_nettype wire

/* bench/adcsc_host.sv */
// host microcontroller model driving the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module adcsc_host (
  // clock
  input  wire logic mclk,
  // serial pins
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  din,
  input  wire logic dout
);
  // ****
  // frame engine
  // ****
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end
  // command byte then n data bits, msb first; sclk idles high between frames
  task automatic access(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                        output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, (n == 16) ? wd : {wd[7:0], 8'h00}};
    rd = 16'h0;
    @(posedge mclk);
    #1 cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      sclk = 1'b0;
      din  = sh[23 - i];
      repeat (5) @(posedge mclk);
      #1 sclk = 1'b1;
      if (i >= 8) rd = {rd[14:0], dout};
      repeat (5) @(posedge mclk);
      #1;
    end
    cs_n = 1'b1;
    din  = ~din;
  endtask
endmodule
`default_nettype wire

/* bench/adcsc_setup_ctrl_bench.sv */
// self-checking bench of the converter setup block
`timescale 1ns/10ps
`default_nettype none
module adcsc_setup_ctrl_bench;
  logic [15:0] sample = 16'h5a3c;
  logic       mclk = 1'b0;
  logic       sys_rst, sclk, cs_n, din, dout, dout_oe, result_ready_n;
  logic       mclk_sel, unipolar, buffer_en, filter_hold, modulator_rst, cal_active, standby;
  logic [1:0] op_mode, update_rate_sel, gain_sel;
  logic [15:0] r;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  always #4 mclk = ~mclk;
  adcsc_setup_ctrl #(.CLK_FREQ_HZ(100000)) dut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .result_ready_n(result_ready_n),
    .sample_word(sample), .op_mode(op_mode), .mclk_sel(mclk_sel),
    .update_rate_sel(update_rate_sel), .unipolar(unipolar), .buffer_en(buffer_en),
    .filter_hold(filter_hold), .modulator_rst(modulator_rst), .cal_active(cal_active),
    .standby(standby), .gain_sel(gain_sel));
  adcsc_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  // ****
  // shared tasks
  // ****
  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 16'h1 : 16'h0;
  endfunction
  task wr(input logic [7:0] v);
    host.access(8'h10, {8'h00, v}, 8, r);
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task wait_rdy(input int lim);
    int n;
    n = 0;
    while (result_ready_n !== 1'b0 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    host.access(8'h18, 16'h0, 8, r);
    chk(r[7:0], 8'h28);
    chk(mclk_sel, 1'b1);
    chk(unipolar, 1'b0);
    host.access(8'h0b, 16'h0, 8, r);
    chk(r[7:0], 8'h8b);
    chk({standby, gain_sel}, 3'h3);
    $display("reset test done");
  endtask
  task t_fields;
    logic [7:0] v[3];
    v = '{8'h3e, 8'h04, 8'h12};
    foreach (v[i]) begin
      wr(v[i]);
      chk({op_mode, mclk_sel, update_rate_sel, unipolar, buffer_en, filter_hold}, v[i]);
      host.access(8'h18, 16'h0, 8, r);
      chk(r[7:0], v[i]);
    end
    $display("field test done");
  endtask
  task t_rate(input logic [2:0] code, input int per);
    int t0;
    wr({2'b00, code, 3'b000});
    sample = ~sample;
    t0 = cyc;
    host.access(8'h38, 16'h0, 16, r);
    wait_rdy(5 * per);
    chk(in_rng(cyc - t0, 2 * per, 4 * per), 16'h1);
    t0 = cyc;
    host.access(8'h38, 16'h0, 16, r);
    chk(r, sample);
    chk(result_ready_n, 1'b1);
    wait_rdy(2 * per);
    chk(in_rng(cyc - t0, per - 2, per + 2), 16'h1);
    $display("rate test done");
  endtask
  task t_hold;
    int t0;
    wr(8'h19);
    host.access(8'h38, 16'h0, 16, r);
    chk(modulator_rst, 1'b1);
    repeat (1600) @(posedge mclk);
    #1 chk(result_ready_n, 1'b1);
    wr(8'h18);
    t0 = cyc;
    wait_rdy(2000);
    chk(in_rng(cyc - t0, 1480, 1505), 16'h1);
    host.access(8'h08, 16'h0, 8, r);
    chk(r[7:0], 8'h08);
    wr(8'h19);
    chk(result_ready_n, 1'b0);
    wr(8'h18);
    $display("hold test done");
  endtask
  task t_cal;
    int t0;
    for (int m = 1; m < 4; m++) begin
      wr({m[1:0], 6'h18});
      t0 = cyc;
      chk({cal_active, result_ready_n}, 2'h3);
      wait_rdy(2500);
      chk(in_rng(cyc - t0, 1700, 2100), 16'h1);
      chk({cal_active, op_mode}, 3'h0);
      host.access(8'h18, 16'h0, 8, r);
      chk(r[7:0], 8'h18);
    end
    $display("calibration test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset;
    t_fields;
    t_rate(3'b011, 500);
    t_rate(3'b110, 400);
    t_hold;
    t_cal;
    tally_and_finish;
  end
endmodule
`default_nettype wire
